// File: design/sync_regs_pkg.sv
// constants for the sync control and user pattern register slice
// assumes a 13-bit register address space reached over the three-wire serial port
//
// Summary of operation
// RQ1: sync functions idle unless master enable set
// RQ2: host keeps master enable low when unused
// RQ3: divider enable bit gates sync to divider
// RQ4: both bits set: every pulse reaches divider
// RQ5: next-only mode: first pulse only, rest ignored
// RQ6: divider enable clears itself after one-shot sync
// RQ7: host sets channel index before config write
// RQ8: host keeps serial port quiet during capture
// RQ9: sync input synchronised, rising edge detected
// RQ10: reserved sync bits ignored, read as zero
`default_nettype none
package sync_regs_pkg;
	localparam int ADDR_W = 13;
	localparam int INSTR_BITS = 16;
	localparam int BYTE_BITS = 8;
	localparam logic [3:0] INSTR_LAST = 4'hf;
	localparam logic [3:0] BYTE_LAST = 4'h7;
	localparam int RW_POS = 15;

	localparam logic [12:0] ADDR_PAT3_LO = 13'h001d;
	localparam logic [12:0] ADDR_PAT3_HI = 13'h001e;
	localparam logic [12:0] ADDR_PAT4_LO = 13'h001f;
	localparam logic [12:0] ADDR_PAT4_HI = 13'h0020;
	localparam logic [12:0] ADDR_SYNC = 13'h003a;

	localparam logic [7:0] PAT_RESET = 8'h00;
	localparam logic [7:0] SYNC_RESET = 8'h00;
	localparam int SYNC_MASTER_POS = 0;
	localparam int SYNC_DIV_EN_POS = 1;
	localparam int SYNC_NEXT_ONLY_POS = 2;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	typedef enum logic [0:0] {
		ST_INSTR = 1'b0,
		ST_DATA = 1'b1
	} spi_state_t;
endpackage
`default_nettype wire

// File: design/sync_ctrl_if.sv
// carries sync control bits from the register bank to the sync gate, and the
// one-shot clear request back; single core_clk domain
`default_nettype none
interface sync_ctrl_if;
	logic master_en;
	logic div_en;
	logic next_only;
	logic clear_req;
	modport regs (output master_en, output div_en, output next_only, input clear_req);
	modport gate (input master_en, input div_en, input next_only, output clear_req);
endinterface
`default_nettype wire

// File: design/sync_gate.sv
// sync pulse gate: synchronises the external sync pin and forwards its rising
// edge to the clock divider under control of the sync register bits
`default_nettype none
module sync_gate (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic sync_in,
	sync_ctrl_if.gate ctl,
	output logic div_sync_pulse
);
	logic meta_ff, sync_s_ff, sync_d_ff, pulse_ff, clr_ff;
	logic rise;

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk) begin
		if (reset) begin
			meta_ff <= 1'b0;
			sync_s_ff <= 1'b0;
			sync_d_ff <= 1'b0;
		end else begin
			meta_ff <= sync_in; // [RQ9]
			sync_s_ff <= meta_ff;
			sync_d_ff <= sync_s_ff;
		end
	end

	assign rise = sync_s_ff & ~sync_d_ff; // [RQ9]

	always_ff @(posedge core_clk) begin
		if (reset) begin
			pulse_ff <= 1'b0;
			clr_ff <= 1'b0;
		end else begin
			pulse_ff <= rise & ctl.master_en & ctl.div_en; // [RQ1] [RQ3] [RQ4]
			// one-shot: ask the bank to drop the enable the moment we pass a pulse
			clr_ff <= rise & ctl.master_en & ctl.div_en & ctl.next_only; // [RQ5] [RQ6]
		end
	end

	assign div_sync_pulse = pulse_ff;
	assign ctl.clear_req = clr_ff;

	////////////////////////////////////////////////////////////////////////////
	property p_master_gate;
		@(posedge core_clk) disable iff (reset)
		pulse_ff |-> $past(ctl.master_en);
	endproperty
	a_master_gate: assert property (p_master_gate) else $error("pulse without master enable"); // [RQ1]

	property p_div_gate;
		@(posedge core_clk) disable iff (reset)
		!ctl.div_en |=> !pulse_ff;
	endproperty
	a_div_gate: assert property (p_div_gate) else $error("pulse with divider enable low"); // [RQ3]

	property p_continuous;
		@(posedge core_clk) disable iff (reset)
		(rise && ctl.master_en && ctl.div_en && !ctl.next_only) |=> pulse_ff && !clr_ff;
	endproperty
	a_continuous: assert property (p_continuous) else $error("continuous pulse lost"); // [RQ4]

	property p_one_shot;
		@(posedge core_clk) disable iff (reset)
		(pulse_ff && $past(ctl.next_only)) |=> !pulse_ff [*2];
	endproperty
	a_one_shot: assert property (p_one_shot) else $error("second pulse in one-shot mode"); // [RQ5]

	property p_edge_only;
		@(posedge core_clk) disable iff (reset)
		pulse_ff |-> $past(sync_s_ff) && !$past(sync_d_ff);
	endproperty
	a_edge_only: assert property (p_edge_only) else $error("pulse without rising edge"); // [RQ9]
endmodule
`default_nettype wire

// File: design/sync_control_and_test_pattern_regs.sv
// register slice: user patterns three and four plus sync control, reached over
// the three-wire serial port; serial pins are sampled as core_clk-synchronous
// inputs, so sclk must run well below core_clk (at most one edge per 2 cycles)
`default_nettype none
module sync_control_and_test_pattern_regs (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe,
	input wire logic sync_in,
	output logic div_sync_pulse,
	output logic sync_buffer_enable,
	output logic [15:0] pattern_three,
	output logic [15:0] pattern_four
);
	sync_ctrl_if sc ();

	sync_regs_pkg::spi_state_t state_ff;
	logic sclk_q_ff;
	logic [3:0] bit_cnt_ff;
	logic [15:0] shift_in_ff;
	logic [15:0] nxt_shift_in;
	logic rw_ff;
	logic [12:0] addr_ff;
	logic [7:0] rd_shift_ff;
	logic sdio_out_ff, sdio_oe_ff;
	logic [7:0] pat3_lo_ff, pat3_hi_ff, pat4_lo_ff, pat4_hi_ff;
	logic master_ff, div_en_ff, next_only_ff;
	logic rise, fall, instr_done, byte_done, wr_fire, rd_load;
	logic [12:0] rd_addr;
	logic [7:0] wr_data;

	////////////////////////////////////////////////////////////////////////////
	// readback mux; reserved sync bits and unmapped addresses read zero
	function automatic logic [7:0] read_reg(input logic [12:0] a, input logic [7:0] p3l,
			input logic [7:0] p3h, input logic [7:0] p4l, input logic [7:0] p4h,
			input logic m, input logic d, input logic n);
		logic [7:0] r;
		r = sync_regs_pkg::UNMAPPED_READ;
		if (a == sync_regs_pkg::ADDR_PAT3_LO) begin
			r = p3l;
		end else if (a == sync_regs_pkg::ADDR_PAT3_HI) begin
			r = p3h;
		end else if (a == sync_regs_pkg::ADDR_PAT4_LO) begin
			r = p4l;
		end else if (a == sync_regs_pkg::ADDR_PAT4_HI) begin
			r = p4h;
		end else if (a == sync_regs_pkg::ADDR_SYNC) begin
			r[sync_regs_pkg::SYNC_MASTER_POS] = m; // [RQ10]
			r[sync_regs_pkg::SYNC_DIV_EN_POS] = d;
			r[sync_regs_pkg::SYNC_NEXT_ONLY_POS] = n;
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// serial framing
	assign rise = spi_sclk & ~sclk_q_ff;
	assign fall = ~spi_sclk & sclk_q_ff;
	assign nxt_shift_in = {shift_in_ff[14:0], sdio_in};
	assign instr_done = rise && !spi_cs_n && state_ff == sync_regs_pkg::ST_INSTR
		&& bit_cnt_ff == sync_regs_pkg::INSTR_LAST;
	assign byte_done = rise && !spi_cs_n && state_ff == sync_regs_pkg::ST_DATA
		&& bit_cnt_ff == sync_regs_pkg::BYTE_LAST;
	assign wr_fire = byte_done && !rw_ff;
	assign wr_data = nxt_shift_in[7:0];
	assign rd_load = instr_done || byte_done;
	// streaming walks the address downward after every byte
	assign rd_addr = instr_done ? nxt_shift_in[12:0] : addr_ff - 13'h0001;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			sclk_q_ff <= 1'b0;
		end else begin
			sclk_q_ff <= spi_sclk;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset || spi_cs_n) begin
			state_ff <= sync_regs_pkg::ST_INSTR;
			bit_cnt_ff <= 4'h0;
		end else if (rise) begin
			case (state_ff)
				sync_regs_pkg::ST_INSTR: begin
					if (bit_cnt_ff == sync_regs_pkg::INSTR_LAST) begin
						state_ff <= sync_regs_pkg::ST_DATA;
						bit_cnt_ff <= 4'h0;
					end else begin
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
					end
				end
				default: begin
					if (bit_cnt_ff == sync_regs_pkg::BYTE_LAST) begin
						bit_cnt_ff <= 4'h0;
					end else begin
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			shift_in_ff <= 16'h0000;
		end else if (rise && !spi_cs_n) begin
			shift_in_ff <= nxt_shift_in;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			rw_ff <= 1'b0;
			addr_ff <= 13'h0000;
		end else if (instr_done) begin
			rw_ff <= nxt_shift_in[sync_regs_pkg::RW_POS];
			addr_ff <= nxt_shift_in[12:0];
		end else if (byte_done) begin
			addr_ff <= addr_ff - 13'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read path: new byte drives out from the sclk falling edge onward
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rd_shift_ff <= 8'h00;
			sdio_out_ff <= 1'b0;
		end else if (rd_load) begin
			rd_shift_ff <= read_reg(rd_addr, pat3_lo_ff, pat3_hi_ff, pat4_lo_ff, pat4_hi_ff,
				master_ff, div_en_ff, next_only_ff);
		end else if (fall && !spi_cs_n && state_ff == sync_regs_pkg::ST_DATA && rw_ff) begin
			sdio_out_ff <= rd_shift_ff[7];
			rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			sdio_oe_ff <= 1'b0;
		end else begin
			sdio_oe_ff <= !spi_cs_n && state_ff == sync_regs_pkg::ST_DATA && rw_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pattern registers
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pat3_lo_ff <= sync_regs_pkg::PAT_RESET;
			pat3_hi_ff <= sync_regs_pkg::PAT_RESET;
			pat4_lo_ff <= sync_regs_pkg::PAT_RESET;
			pat4_hi_ff <= sync_regs_pkg::PAT_RESET;
		end else if (wr_fire) begin
			if (addr_ff == sync_regs_pkg::ADDR_PAT3_LO) begin
				pat3_lo_ff <= wr_data;
			end else if (addr_ff == sync_regs_pkg::ADDR_PAT3_HI) begin
				pat3_hi_ff <= wr_data;
			end else if (addr_ff == sync_regs_pkg::ADDR_PAT4_LO) begin
				pat4_lo_ff <= wr_data;
			end else if (addr_ff == sync_regs_pkg::ADDR_PAT4_HI) begin
				pat4_hi_ff <= wr_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sync control; bits 7:3 have no storage
	always_ff @(posedge core_clk) begin
		if (reset) begin
			master_ff <= sync_regs_pkg::SYNC_RESET[sync_regs_pkg::SYNC_MASTER_POS];
			next_only_ff <= sync_regs_pkg::SYNC_RESET[sync_regs_pkg::SYNC_NEXT_ONLY_POS];
		end else if (wr_fire && addr_ff == sync_regs_pkg::ADDR_SYNC) begin
			master_ff <= wr_data[sync_regs_pkg::SYNC_MASTER_POS]; // [RQ1] [RQ10]
			next_only_ff <= wr_data[sync_regs_pkg::SYNC_NEXT_ONLY_POS];
		end
	end

	// a fresh software write beats a same-cycle one-shot clear; a re-arm written one cycle before clear_req is still cleared
	always_ff @(posedge core_clk) begin
		if (reset) begin
			div_en_ff <= sync_regs_pkg::SYNC_RESET[sync_regs_pkg::SYNC_DIV_EN_POS];
		end else if (wr_fire && addr_ff == sync_regs_pkg::ADDR_SYNC) begin
			div_en_ff <= wr_data[sync_regs_pkg::SYNC_DIV_EN_POS]; // [RQ3]
		end else if (sc.clear_req) begin
			div_en_ff <= 1'b0; // [RQ6]
		end
	end

	assign sc.master_en = master_ff;
	assign sc.div_en = div_en_ff;
	assign sc.next_only = next_only_ff;

	sync_gate u_gate (
		.core_clk(core_clk),
		.reset(reset),
		.sync_in(sync_in),
		.ctl(sc),
		.div_sync_pulse(div_sync_pulse)
	);

	assign sdio_out = sdio_out_ff;
	assign sdio_oe = sdio_oe_ff;
	assign sync_buffer_enable = master_ff;
	assign pattern_three = {pat3_hi_ff, pat3_lo_ff};
	assign pattern_four = {pat4_hi_ff, pat4_lo_ff};

	////////////////////////////////////////////////////////////////////////////
	property p_self_clear;
		@(posedge core_clk) disable iff (reset)
		(sc.clear_req && !(wr_fire && addr_ff == sync_regs_pkg::ADDR_SYNC)) |=> !div_en_ff;
	endproperty
	a_self_clear: assert property (p_self_clear) else $error("divider enable not cleared"); // [RQ6]

	property p_reserved_zero;
		@(posedge core_clk) disable iff (reset)
		(rd_load && rd_addr == sync_regs_pkg::ADDR_SYNC) |=> rd_shift_ff[7:3] == 5'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero"); // [RQ10]

	property p_div_write;
		@(posedge core_clk) disable iff (reset)
		(wr_fire && addr_ff == sync_regs_pkg::ADDR_SYNC)
			|=> div_en_ff == $past(wr_data[sync_regs_pkg::SYNC_DIV_EN_POS])
			&& master_ff == $past(wr_data[sync_regs_pkg::SYNC_MASTER_POS]);
	endproperty
	a_div_write: assert property (p_div_write) else $error("sync control write lost"); // [RQ3]
endmodule
`default_nettype wire

// File: sim/spi_host_model.sv
// host side of the three-wire serial port: frames register writes and reads
// assumes the bench resolves the shared data wire from the device's sdio_oe
`default_nettype none
module spi_host_model (
	input wire logic core_clk,
	output logic spi_sclk,
	output logic spi_cs_n,
	output logic sdio_host,
	input wire logic sdio_wire
);
	timeunit 1ns;
	timeprecision 1ps;

	// lines stay static between frames, so nothing toggles while converting
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		sdio_host = 1'b0;
	end

	task automatic half(input logic lvl);
		spi_sclk <= lvl;
		repeat (2) @(posedge core_clk);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// address zero is never written here, so the channel index needs no setup
	task automatic xfer(input logic rd, input logic [12:0] addr, input int nbytes,
			input logic [15:0] wd, output logic [15:0] rdata);
		logic [15:0] instr;
		int nbits;
		instr = {rd, 2'b00, addr};
		nbits = 16 + 8 * nbytes;
		rdata = 16'h0000;
		@(posedge core_clk);
		spi_cs_n <= 1'b0;
		for (int i = 0; i < nbits; i++) begin
			if (i < 16)
				sdio_host <= instr[15 - i];
			else if (!rd)
				sdio_host <= wd[nbits - 1 - i];
			else if (i == 16)
				sdio_host <= ~sdio_host; // released: a stale bit must not pass
			half(1'b0);
			half(1'b1);
			if (rd && i >= 16)
				rdata = {rdata[14:0], sdio_wire};
		end
		spi_sclk <= 1'b0;
		spi_cs_n <= 1'b1;
		sdio_host <= ~sdio_host;
		repeat (2) @(posedge core_clk);
	endtask
endmodule
`default_nettype wire

// File: sim/sync_control_and_test_pattern_regs_tb.sv
// self-checking bench for the pattern and sync control register slice
// assumes the host model frames all serial traffic; sync pin driven here
`default_nettype none
module sync_control_and_test_pattern_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [12:0] addr; logic [7:0] wd; logic [7:0] exp;} row_t;
	logic core_clk, reset, spi_sclk, spi_cs_n, sdio_host, sdio_in, sdio_out, sdio_oe;
	logic sync_in, div_sync_pulse, sync_buffer_enable;
	logic [15:0] pattern_three, pattern_four, rdata;
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	int cnt, first;
	row_t rows [8] = '{'{13'h001d, 8'ha5, 8'ha5}, '{13'h001e, 8'h5a, 8'h5a},
		'{13'h001f, 8'h3c, 8'h3c}, '{13'h0020, 8'hc3, 8'hc3}, '{13'h003a, 8'hf8, 8'h00},
		'{13'h0021, 8'h77, 8'h00}, '{13'h001c, 8'h11, 8'h00}, '{13'h003a, 8'hfa, 8'h02}};

	// device drives the shared wire only while its enable is high
	assign sdio_in = sdio_oe ? sdio_out : sdio_host;

	sync_control_and_test_pattern_regs u_sync_control_and_test_pattern_regs (
		.core_clk, .reset, .spi_sclk, .spi_cs_n, .sdio_in, .sdio_out, .sdio_oe,
		.sync_in, .div_sync_pulse, .sync_buffer_enable, .pattern_three, .pattern_four);
	spi_host_model u_spi_host_model (.core_clk, .spi_sclk, .spi_cs_n, .sdio_host,
		.sdio_wire(sdio_in));

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		if (num_errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// run is about 3450 cycles; the ceiling leaves wide margin
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			wrap_up();
		end
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		u_spi_host_model.xfer(1'b0, a, 1, {8'h00, d}, rdata);
	endtask

	task automatic rd(input logic [12:0] a, input int n);
		u_spi_host_model.xfer(1'b1, a, n, 16'h0000, rdata);
	endtask

	// holds the pin high for eleven cycles; only its rising edge may count
	task automatic pulse_sync();
		cnt = 0;
		first = -1;
		@(posedge core_clk);
		sync_in <= 1'b1;
		for (int i = 1; i <= 10; i++) begin
			@(posedge core_clk);
			#1;
			// an unknown on the pulse counts as a pulse so it cannot slip through
			if (div_sync_pulse !== 1'b0) begin
				cnt++;
				if (first < 0)
					first = i;
			end
		end
		@(posedge core_clk);
		sync_in <= 1'b0;
		repeat (6) @(posedge core_clk);
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		reset = 1'b1;
		sync_in = 1'b0;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		foreach (rows[k]) begin
			rd(rows[k].addr, 1);
			check(rdata, 16'h0000);
			wr(rows[k].addr, rows[k].wd);
			rd(rows[k].addr, 1);
			check(rdata, {8'h00, rows[k].exp});
		end
		check(pattern_three, 16'h5aa5);
		check(pattern_four, 16'hc33c);
		pulse_sync();
		check(16'(cnt), 16'h0000);
		check({15'h0000, sync_buffer_enable}, 16'h0000);
		wr(13'h003a, 8'h01);
		check({15'h0000, sync_buffer_enable}, 16'h0001);
		pulse_sync();
		check(16'(cnt), 16'h0000);
		wr(13'h003a, 8'h03);
		pulse_sync();
		check(16'(cnt), 16'h0001);
		check(16'(first), 16'h0003);
		pulse_sync();
		check(16'(cnt), 16'h0001);
		rd(13'h003a, 1);
		check(rdata, 16'h0003);
		wr(13'h003a, 8'h07);
		pulse_sync();
		check(16'(cnt), 16'h0001);
		rd(13'h003a, 1);
		check(rdata, 16'h0005);
		pulse_sync();
		check(16'(cnt), 16'h0000);
		// sync no longer needed: master enable goes back low
		wr(13'h003a, 8'h00);
		check({15'h0000, sync_buffer_enable}, 16'h0000);
		u_spi_host_model.xfer(1'b0, 13'h0020, 2, 16'h1234, rdata);
		check(pattern_four, 16'h1234);
		rd(13'h0020, 2);
		check(rdata, 16'h1234);
		wr(13'h003a, 8'h01);
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		#1;
		check(pattern_four, 16'h0000);
		check(pattern_three, 16'h0000);
		check({15'h0000, sdio_oe}, 16'h0000);
		check({15'h0000, div_sync_pulse}, 16'h0000);
		check({15'h0000, sync_buffer_enable}, 16'h0000);
		wrap_up();
	end
endmodule
`default_nettype wire
